// *** design/dvitx_input_control.sv ***
// Input control of the video transmitter: serial slave, config, monitor, enable generator
`timescale 1ns/100ps
module dvitx_input_control import dvitx_pkg::*; (
   input wire logic i_clk, // System clock
   input wire logic i_nrst, // Asynchronous reset
   input wire logic i_pixel_input_clock, // Pixel clock from controller
   input wire logic i_config_select_reset, // Serial select and reset pin
   input wire dvitx_pin_type i_pin_cfg, // Configuration pins
   input wire logic [2:0] i_slave_addr_pins,
   input wire logic i_hot_plug_detect,
   input wire logic i_receiver_sense,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   output logic o_monitor_sense_output,
   output dvitx_cfg_type o_cfg,
   output logic [10:0] o_measured_pixel_total,
   output logic [10:0] o_measured_line_total,
   input wire logic [23:0] i_pix_data,
   input wire logic i_data_enable,
   input wire logic i_hsync,
   input wire logic i_vsync,
   output dvitx_pixel_type o_pixel,
   output logic o_data_enable,
   output logic o_hsync,
   output logic o_vsync
);
   // System domain state
   typedef struct packed {
      dvitx_async_type s1; // First synchroniser stage
      dvitx_async_type s2; // Second synchroniser stage
      logic scl_d; logic sda_d; logic tog_d;
      dvitx_state_type state;
      logic [1:0] kind; logic [3:0] cnt; logic [7:0] shreg;
      logic rw; logic [7:0] sub; logic sda_drv;
      logic [7:0] ctl1; logic [7:0] ctl2; logic [7:0] ctl3;
      dvitx_gen_type gen;
      logic flag; logic src_prev;
      logic [10:0] htot; logic [10:0] vtot;
      dvitx_cfg_type cfg; logic monitor_sense_output;
   } dvitx_sys_type;
   // Pixel domain state
   typedef struct packed {
      dvitx_gen_type c1; dvitx_gen_type c2;
      logic hs_prev; logic vs_prev;
      logic [10:0] pcnt; logic [10:0] lcnt; logic [10:0] hcur;
      logic [10:0] hhold; logic [10:0] vhold; logic tog;
      dvitx_pixel_type pixel; logic de; logic hs; logic vs;
   } dvitx_pix_type;

   dvitx_sys_type st_ff, nxt_st;
   dvitx_pix_type px_ff, nxt_px;
   dvitx_async_type async_in; // Raw pins gathered for the synchroniser
   logic ser_en, scl_rise, scl_fall, start, stop;
   logic receiver_sense, hpd, src, change, clr, wr_strobe;
   logic reg_pd, reg_deskew_enable;
   logic [7:0] rd;
   logic hs_act, vs_act, hs_edge, vs_edge, hwin, vwin;

   // Register read decode
   function automatic logic [7:0] read_byte(input logic [7:0] a, input dvitx_sys_type s,
                                            input logic r, input logic h);
      logic [7:0] v;
      v = 8'h00; // Unmapped reads as zero
      unique case (a)
         REG_CTL1: v = s.ctl1;
         REG_CTL2: v = {s.ctl2[7:3], r, h, s.flag};
         REG_CTL3: v = s.ctl3;
         REG_HOFF: v = s.gen.h_off[7:0];
         REG_GCTL: v = {1'b0, s.gen.gen_on, s.gen.vertical_sync_polarity, s.gen.horizontal_sync_polarity, 3'h0, s.gen.h_off[8]};
         REG_VOFF: v = {1'b0, s.gen.v_off};
         REG_HLEN_LO: v = s.gen.h_len[7:0];
         REG_HLEN_HI: v = {5'h00, s.gen.h_len[10:8]};
         REG_VLEN_LO: v = s.gen.v_len[7:0];
         REG_VLEN_HI: v = {5'h00, s.gen.v_len[10:8]};
         REG_HTOT_LO: v = s.htot[7:0];
         REG_HTOT_HI: v = {5'h00, s.htot[10:8]};
         REG_VTOT_LO: v = s.vtot[7:0];
         REG_VTOT_HI: v = {5'h00, s.vtot[10:8]};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // Pins into the system domain
   assign async_in = '{isel: i_config_select_reset, scl: i_scl, sda: i_sda,
                       hpd: i_hot_plug_detect, receiver_sense: i_receiver_sense,
                       addr: i_slave_addr_pins, pin: i_pin_cfg, tog: px_ff.tog};
   // Bus conditions seen after synchronisation
   assign ser_en = st_ff.s2.isel;
   assign scl_rise = st_ff.s2.scl & ~st_ff.scl_d;
   assign scl_fall = ~st_ff.s2.scl & st_ff.scl_d;
   assign start = st_ff.scl_d & st_ff.s2.scl & st_ff.sda_d & ~st_ff.s2.sda;
   assign stop = st_ff.scl_d & st_ff.s2.scl & ~st_ff.sda_d & st_ff.s2.sda;
   assign receiver_sense = st_ff.s2.receiver_sense;
   assign hpd = st_ff.s2.hpd;
   assign src = st_ff.ctl2[CTL2_INTERRUPT_SOURCE_SELECT] ? receiver_sense : hpd;
   assign change = src != st_ff.src_prev;
   assign clr = wr_strobe && st_ff.sub == REG_CTL2 && st_ff.shreg[CTL2_MDI];
   assign rd = read_byte(st_ff.sub, st_ff, receiver_sense, hpd);
   assign reg_pd = st_ff.ctl1[CTL1_PD];
   assign reg_deskew_enable = st_ff.ctl3[CTL3_DESKEW_ENABLE];

   // System domain next state: slave, registers, monitor, config muxes
   always_comb begin
      nxt_st = st_ff;
      wr_strobe = 1'b0;
      nxt_st.s1 = async_in;
      nxt_st.s2 = st_ff.s1;
      nxt_st.scl_d = st_ff.s2.scl;
      nxt_st.sda_d = st_ff.s2.sda;
      nxt_st.tog_d = st_ff.s2.tog;
      // Slave is held idle while serial access is off
      if (!ser_en || stop) begin
         nxt_st.state = ST_IDLE;
         nxt_st.sda_drv = 1'b0;
      end else if (start) begin
         nxt_st.state = ST_RX;
         nxt_st.kind = KIND_ADDR;
         nxt_st.cnt = 4'h0;
         nxt_st.sda_drv = 1'b0;
      end else begin
         unique case (st_ff.state)
            ST_IDLE: begin
               nxt_st.sda_drv = 1'b0;
            end
            ST_RX: begin
               if (scl_rise) begin
                  nxt_st.shreg = {st_ff.shreg[6:0], st_ff.s2.sda};
                  nxt_st.cnt = st_ff.cnt + 4'h1;
               end else if (scl_fall && st_ff.cnt == BITS_BYTE) begin
                  nxt_st.cnt = 4'h0;
                  nxt_st.state = ST_ACK;
                  nxt_st.sda_drv = 1'b1;
                  unique case (st_ff.kind)
                     KIND_ADDR: begin
                        // Address match on fixed nibble plus pins
                        if (st_ff.shreg[7:1] != {SLAVE_ADDR_HI, st_ff.s2.addr}) begin
                           nxt_st.state = ST_IDLE;
                           nxt_st.sda_drv = 1'b0;
                        end else begin
                           nxt_st.rw = st_ff.shreg[0];
                        end
                     end
                     KIND_SUB: nxt_st.sub = st_ff.shreg;
                     KIND_DATA: wr_strobe = 1'b1;
                     KIND_DONE: begin
                        // No pointer advance, so a second data byte is not acked
                        nxt_st.state = ST_IDLE;
                        nxt_st.sda_drv = 1'b0;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (st_ff.rw) begin
                     nxt_st.state = ST_TX;
                     nxt_st.shreg = rd;
                     nxt_st.sda_drv = ~rd[7];
                  end else begin
                     nxt_st.state = ST_RX;
                     nxt_st.sda_drv = 1'b0;
                     nxt_st.kind = st_ff.kind + 2'h1;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (st_ff.cnt == BITS_LAST) begin
                     nxt_st.state = ST_TXACK;
                     nxt_st.sda_drv = 1'b0;
                  end else begin
                     nxt_st.cnt = st_ff.cnt + 4'h1;
                     nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
                     nxt_st.sda_drv = ~st_ff.shreg[6];
                  end
               end
            end
            ST_TXACK: begin
               // One byte per read, whatever the master acks
               if (scl_fall) begin
                  nxt_st.state = ST_IDLE;
               end
            end
            default: begin
               nxt_st.state = ST_IDLE;
               nxt_st.sda_drv = 1'b0;
            end
         endcase
      end
      // Register file, reset while the select pin is low
      nxt_st.src_prev = src;
      if (!ser_en) begin
         nxt_st.ctl1 = CTL1_RST;
         nxt_st.ctl2 = CTL2_RST;
         nxt_st.ctl3 = CTL3_RST;
         nxt_st.gen = '0;
         nxt_st.flag = 1'b0;
      end else begin
         // Set beats a clear in the same cycle
         nxt_st.flag = (st_ff.flag & ~clr) | change;
         if (wr_strobe) begin
            unique case (st_ff.sub)
               REG_CTL1: nxt_st.ctl1 = st_ff.shreg;
               REG_CTL2: nxt_st.ctl2 = {st_ff.shreg[7:3], 3'h0};
               REG_CTL3: nxt_st.ctl3 = st_ff.shreg;
               REG_HOFF: nxt_st.gen.h_off[7:0] = st_ff.shreg;
               REG_GCTL: begin
                  nxt_st.gen.gen_on = st_ff.shreg[6];
                  nxt_st.gen.vertical_sync_polarity = st_ff.shreg[5];
                  nxt_st.gen.horizontal_sync_polarity = st_ff.shreg[4];
                  nxt_st.gen.h_off[8] = st_ff.shreg[0];
               end
               REG_VOFF: nxt_st.gen.v_off = st_ff.shreg[6:0];
               REG_HLEN_LO: nxt_st.gen.h_len[7:0] = st_ff.shreg;
               REG_HLEN_HI: nxt_st.gen.h_len[10:8] = st_ff.shreg[2:0];
               REG_VLEN_LO: nxt_st.gen.v_len[7:0] = st_ff.shreg;
               REG_VLEN_HI: nxt_st.gen.v_len[10:8] = st_ff.shreg[2:0];
               default: ; // Read-only or unmapped: write dropped
            endcase
         end
      end
      // Totals captured once per frame; pixel side holds them steady
      if (st_ff.s2.tog != st_ff.tog_d) begin
         nxt_st.htot = px_ff.hhold;
         nxt_st.vtot = px_ff.vhold;
      end
      // Configuration source by the select pin
      if (ser_en) begin
         nxt_st.cfg.bus_width = st_ff.ctl1[CTL1_BUS_WIDTH_SELECT];
         nxt_st.cfg.clock_mode = st_ff.ctl1[CTL1_CLOCK_MODE_SELECT];
         nxt_st.cfg.latch_edge = st_ff.ctl1[CTL1_EDGE];
         nxt_st.cfg.power_down = ~reg_pd;
         nxt_st.cfg.deskew_setting = reg_deskew_enable ? st_ff.ctl3[CTL3_DK +: 3] : DESKEW_DEFAULT;
      end else begin
         nxt_st.cfg.bus_width = st_ff.s2.pin.bus_width;
         nxt_st.cfg.clock_mode = st_ff.s2.pin.clock_mode;
         nxt_st.cfg.latch_edge = st_ff.s2.pin.latch_edge;
         nxt_st.cfg.power_down = ~st_ff.s2.pin.normal_op;
         // Tap code 0..7 feeds the delay line; the clock itself is untouched
         nxt_st.cfg.deskew_setting = st_ff.s2.pin.deskew_enable ?
                                     st_ff.s2.pin.deskew_amount : DESKEW_DEFAULT;
      end
      // Monitor sense output
      if (!ser_en) begin
         nxt_st.monitor_sense_output = receiver_sense;
      end else begin
         unique case (st_ff.ctl2[CTL2_SENSE_OUTPUT_SELECT +: 3])
            SENSE_OUTPUT_SELECT_INT: nxt_st.monitor_sense_output = st_ff.flag;
            SENSE_OUTPUT_SELECT_RECEIVER_SENSE: nxt_st.monitor_sense_output = receiver_sense;
            SENSE_OUTPUT_SELECT_HPD: nxt_st.monitor_sense_output = hpd;
            default: nxt_st.monitor_sense_output = 1'b0; // Disabled
         endcase
      end
   end

   // System domain registers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_ff <= '{state: ST_IDLE, ctl1: CTL1_RST, ctl2: CTL2_RST, ctl3: CTL3_RST,
                    cfg: '{power_down: 1'b1, deskew_setting: DESKEW_DEFAULT, default: 1'b0},
                    default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Sync activity in chosen polarity
   assign hs_act = i_hsync == px_ff.c2.horizontal_sync_polarity;
   assign vs_act = i_vsync == px_ff.c2.vertical_sync_polarity;
   assign hs_edge = hs_act & ~px_ff.hs_prev;
   assign vs_edge = vs_act & ~px_ff.vs_prev;
   assign hwin = {1'b0, px_ff.pcnt} >= {3'h0, px_ff.c2.h_off} &&
                 {1'b0, px_ff.pcnt} < {3'h0, px_ff.c2.h_off} + {1'b0, px_ff.c2.h_len};
   assign vwin = {1'b0, px_ff.lcnt} >= {5'h00, px_ff.c2.v_off} &&
                 {1'b0, px_ff.lcnt} < {5'h00, px_ff.c2.v_off} + {1'b0, px_ff.c2.v_len};

   // Pixel domain next state: latch, counters, enable generator
   always_comb begin
      nxt_px = px_ff;
      // Generator settings are static while in use, so a level sync suffices
      nxt_px.c1 = st_ff.gen;
      nxt_px.c2 = px_ff.c1;
      nxt_px.hs_prev = hs_act;
      nxt_px.vs_prev = vs_act;
      if (hs_edge) begin
         nxt_px.pcnt = 11'h000;
         nxt_px.hcur = px_ff.pcnt + 11'h001;
         if (px_ff.lcnt != 11'h7FF) begin
            nxt_px.lcnt = px_ff.lcnt + 11'h001;
         end
      end else if (px_ff.pcnt != 11'h7FF) begin
         nxt_px.pcnt = px_ff.pcnt + 11'h001;
      end
      if (vs_edge) begin
         nxt_px.lcnt = 11'h000;
         nxt_px.hhold = px_ff.hcur;
         // The sync pulse that opens the frame is one of its lines too
         nxt_px.vhold = px_ff.lcnt + 11'h001;
         nxt_px.tog = ~px_ff.tog;
      end
      nxt_px.pixel = i_pix_data;
      nxt_px.de = px_ff.c2.gen_on ? (hwin & vwin) : i_data_enable;
      nxt_px.hs = i_hsync;
      nxt_px.vs = i_vsync;
   end

   // Pixel domain registers
   always_ff @(posedge i_pixel_input_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         px_ff <= '0;
      end else begin
         px_ff <= nxt_px;
      end
   end

   assign o_sda_out = 1'b0;
   assign o_sda_oe_n = ~st_ff.sda_drv;
   assign o_monitor_sense_output = st_ff.monitor_sense_output;
   assign o_cfg = st_ff.cfg;
   assign o_measured_pixel_total = st_ff.htot;
   assign o_measured_line_total = st_ff.vtot;
   assign o_pixel = px_ff.pixel;
   assign o_data_enable = px_ff.de;
   assign o_hsync = px_ff.hs;
   assign o_vsync = px_ff.vs;

   // Checks
   a_flag_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ser_en && change |=> st_ff.flag) else $error("change lost");
   a_flag_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ser_en && st_ff.flag && !clr |=> st_ff.flag || !ser_en) else $error("flag dropped");
   a_flag_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ser_en && clr && !change |=> !st_ff.flag) else $error("flag not cleared");
   a_monitor_sense_output_pin_mode: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !ser_en |=> o_monitor_sense_output == $past(receiver_sense)) else $error("sense not receiver_sense");
   a_monitor_sense_output_hpd_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ser_en && st_ff.ctl2[6:4] == SENSE_OUTPUT_SELECT_HPD |=> o_monitor_sense_output == $past(hpd))
      else $error("sense not hot plug");
   a_cfg_from_regs: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ser_en |=> o_cfg.power_down == !$past(reg_pd)) else $error("power down wrong");
   a_deskew_dflt: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ser_en && !reg_deskew_enable |=> o_cfg.deskew_setting == DESKEW_DEFAULT) else $error("deskew");
   a_regs_reset: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !ser_en |=> st_ff.ctl1 == CTL1_RST && st_ff.gen == '0) else $error("regs kept");
   a_byte_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ser_en && !start && !stop && st_ff.state == ST_TXACK && scl_fall
      |=> st_ff.state == ST_IDLE) else $error("second byte");
   a_de_bypass: assert property (@(posedge i_pixel_input_clock) disable iff (!i_nrst)
      !px_ff.c2.gen_on |=> o_data_enable == $past(i_data_enable)) else $error("de");
   a_rgb_lanes: assert property (@(posedge i_pixel_input_clock) disable iff (!i_nrst)
      1'b1 |=> o_pixel.red == $past(i_pix_data[23:16]) && o_pixel.green == $past(i_pix_data[15:8])
      && o_pixel.blue == $past(i_pix_data[7:0])) else $error("lanes");
   a_hcnt_restart: assert property (@(posedge i_pixel_input_clock) disable iff (!i_nrst)
      hs_edge |=> px_ff.pcnt == 11'h000 ##1 px_ff.pcnt == 11'h001 || hs_edge)
      else $error("count restart");
endmodule // dvitx_input_control

// *** design/dvitx_pkg.sv ***
// Shared constants and types of the video transmitter input control
package dvitx_pkg;
   localparam logic [3:0] SLAVE_ADDR_HI = 4'h7; // Fixed upper address nibble
   // Serial register sub-addresses
   localparam logic [7:0] REG_CTL1 = 8'h08;
   localparam logic [7:0] REG_CTL2 = 8'h09;
   localparam logic [7:0] REG_CTL3 = 8'h0A;
   localparam logic [7:0] REG_HOFF = 8'h32;
   localparam logic [7:0] REG_GCTL = 8'h33;
   localparam logic [7:0] REG_VOFF = 8'h34;
   localparam logic [7:0] REG_HLEN_LO = 8'h36;
   localparam logic [7:0] REG_HLEN_HI = 8'h37;
   localparam logic [7:0] REG_VLEN_LO = 8'h38;
   localparam logic [7:0] REG_VLEN_HI = 8'h39;
   localparam logic [7:0] REG_HTOT_LO = 8'h3A;
   localparam logic [7:0] REG_HTOT_HI = 8'h3B;
   localparam logic [7:0] REG_VTOT_LO = 8'h3C;
   localparam logic [7:0] REG_VTOT_HI = 8'h3D;
   // Values after reset
   localparam logic [7:0] CTL1_RST = 8'hFE;
   localparam logic [7:0] CTL2_RST = 8'h00;
   localparam logic [7:0] CTL3_RST = 8'h00;
   // Field positions
   localparam int CTL1_PD = 0;
   localparam int CTL1_EDGE = 1;
   localparam int CTL1_BUS_WIDTH_SELECT = 2;
   localparam int CTL1_CLOCK_MODE_SELECT = 3;
   localparam int CTL2_MDI = 0;
   localparam int CTL2_INTERRUPT_SOURCE_SELECT = 3;
   localparam int CTL2_SENSE_OUTPUT_SELECT = 4;
   localparam int CTL3_DESKEW_ENABLE = 4;
   localparam int CTL3_DK = 5;
   // Sense output select codes
   localparam logic [2:0] SENSE_OUTPUT_SELECT_OFF = 3'h0;
   localparam logic [2:0] SENSE_OUTPUT_SELECT_INT = 3'h1;
   localparam logic [2:0] SENSE_OUTPUT_SELECT_RECEIVER_SENSE = 3'h2;
   localparam logic [2:0] SENSE_OUTPUT_SELECT_HPD = 3'h3;
   localparam logic [2:0] DESKEW_DEFAULT = 3'h4; // Zero shift
   // Byte kinds of a serial write
   localparam logic [1:0] KIND_ADDR = 2'h0;
   localparam logic [1:0] KIND_SUB = 2'h1;
   localparam logic [1:0] KIND_DATA = 2'h2;
   localparam logic [1:0] KIND_DONE = 2'h3;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [3:0] BITS_LAST = 4'h7;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_RX = 5'h02, ST_ACK = 5'h04, ST_TX = 5'h08, ST_TXACK = 5'h10
   } dvitx_state_type;
   typedef struct packed {
      logic gen_on; logic vertical_sync_polarity; logic horizontal_sync_polarity; logic [8:0] h_off;
      logic [10:0] h_len; logic [6:0] v_off; logic [10:0] v_len;
   } dvitx_gen_type;
   typedef struct packed {
      logic bus_width; logic clock_mode; logic latch_edge; logic normal_op;
      logic deskew_enable; logic [2:0] deskew_amount;
   } dvitx_pin_type;
   typedef struct packed {
      logic bus_width; logic clock_mode; logic latch_edge; logic power_down;
      logic [2:0] deskew_setting;
   } dvitx_cfg_type;
   typedef struct packed {logic [7:0] red; logic [7:0] green; logic [7:0] blue;} dvitx_pixel_type;
   typedef struct packed {
      logic isel; logic scl; logic sda; logic hpd; logic receiver_sense; logic [2:0] addr;
      dvitx_pin_type pin; logic tog;
   } dvitx_async_type;
endpackage

// *** sim/dvitx_gfx_model.sv ***
// Graphics controller model: a small repeating frame on the pixel clock
`timescale 1ns/100ps
module dvitx_gfx_model (
   input wire logic i_clk, // Pixel clock
   input wire logic i_nrst,
   output logic [23:0] o_pix_data = 24'h0,
   output logic o_data_enable = 1'b0,
   output logic o_hsync = 1'b0,
   output logic o_vsync = 1'b0
);
   int x = 0; // Pixel within a 16 pixel line
   int y = 0; // Line within an 8 line frame
   // Launch shortly after the edge so the latch sees settled data
   always @(posedge i_clk) begin
      #2;
      x = i_nrst ? (x + 1) % 16 : 0;
      if (!i_nrst) begin
         y = 0;
      end else if (x == 0) begin
         y = (y + 1) % 8;
      end
      // Lanes differ so a swap shows up
      o_pix_data = {8'(x), 8'(y * 16 + x), 8'(x) ^ 8'hA5};
      o_data_enable = (x >= 2); // Deliberately unlike the generated window
      o_hsync = (x < 2);
      o_vsync = (y == 0);
   end
endmodule // dvitx_gfx_model

// *** sim/tb.sv ***
// Self-checking bench for the video transmitter input control
`timescale 1ns/100ps
module tb;
   import dvitx_pkg::*;
   localparam logic [7:0] WA = {SLAVE_ADDR_HI, 3'h5, 1'b0}; // Write address from pins 101
   logic clk = 1'b0;
   logic pclk = 1'b0; // Pixel clock, 15 ns
   logic nrst = 1'b0;
   logic sel = 1'b0; // Pin configuration first, held low through power-up
   dvitx_pin_type pins = 8'h5E;
   logic hpd = 1'b0;
   logic receiver_sense = 1'b0;
   logic scl = 1'b1;
   logic sda_m = 1'b1; // Bench side of the open-drain line
   logic sda, sda_out, sda_oe_n, monitor_sense_output, ode, ohs, ovs, pde, phs, pvs, ack;
   dvitx_cfg_type cfg;
   dvitx_pixel_type opix;
   logic [10:0] ptot, ltot;
   logic [23:0] pix;
   logic [7:0] rb;
   int miscompares = 0;
   int total_checks = 0;
   int n;
   always #25 clk = ~clk;
   initial begin
      #3;
      forever #7.5 pclk = ~pclk;
   end
   // Pulled-up line, low while either side pulls it
   assign sda = sda_m & (sda_oe_n | sda_out);
   dvitx_input_control uut (.i_clk(clk), .i_nrst(nrst), .i_pixel_input_clock(pclk),
      .i_config_select_reset(sel), .i_pin_cfg(pins), .i_slave_addr_pins(3'h5),
      .i_hot_plug_detect(hpd), .i_receiver_sense(receiver_sense), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_monitor_sense_output(monitor_sense_output), .o_cfg(cfg),
      .o_measured_pixel_total(ptot), .o_measured_line_total(ltot), .i_pix_data(pix),
      .i_data_enable(pde), .i_hsync(phs), .i_vsync(pvs), .o_pixel(opix),
      .o_data_enable(ode), .o_hsync(ohs), .o_vsync(ovs));
   dvitx_gfx_model gfx (.i_clk(pclk), .i_nrst(nrst), .o_pix_data(pix), .o_data_enable(pde),
      .o_hsync(phs), .o_vsync(pvs));
   task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #2;
   endtask
   // One bus step; 8 clocks keeps each level well past the synchronisers
   task automatic drv(input logic c, input logic d);
      scl = c;
      sda_m = d;
      tick(8);
   endtask
   task automatic start;
      drv(1'b0, sda_m);
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b1);
      drv(1'b1, 1'b0);
      drv(1'b0, 1'b0);
   endtask
   task automatic stop;
      drv(1'b0, sda_m);
      drv(1'b0, 1'b0);
      drv(1'b1, 1'b0);
      drv(1'b1, 1'b1);
   endtask
   // Data only moves while the clock is low, so no false start or stop
   task automatic byte_out(input logic [7:0] b, output logic a);
      for (int i = 7; i >= -1; i--) begin
         drv(1'b0, sda_m);
         drv(1'b0, (i < 0) ? 1'b1 : b[i]);
         drv(1'b1, sda_m);
      end
      a = ~sda;
   endtask
   task automatic byte_in(output logic [7:0] b);
      for (int i = 7; i >= -1; i--) begin
         drv(1'b0, sda_m);
         drv(1'b0, 1'b1);
         drv(1'b1, 1'b1);
         if (i >= 0) begin
            b[i] = sda;
         end
      end
   endtask
   task automatic reg_wr(input logic [7:0] sub, input logic [7:0] d);
      logic a1, a2, a3;
      start;
      byte_out(WA, a1);
      byte_out(sub, a2);
      byte_out(d, a3);
      stop;
      chk_val({a1, a2, a3}, 3'b111);
   endtask
   task automatic rd_ck(input logic [7:0] sub, input logic [7:0] exp);
      start;
      byte_out(WA, ack);
      byte_out(sub, ack);
      start;
      byte_out(WA | 8'h01, ack);
      byte_in(rb);
      stop;
      chk_val(rb, exp);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      tick(16);
      nrst = 1'b1;
      for (int a = 0; a < 8; a++) begin
         pins.deskew_amount = 3'(a);
         tick(8);
         chk_val(cfg, {4'b0100, 3'(a)});
      end
      pins.deskew_enable = 1'b0;
      receiver_sense = 1'b1;
      tick(8);
      chk_val({cfg, monitor_sense_output}, {4'b0100, DESKEW_DEFAULT, 1'b1});
      sel = 1'b1;
      tick(8);
      chk_val(cfg, {4'b1111, DESKEW_DEFAULT});
      reg_wr(REG_CTL1, 8'h0D);
      reg_wr(REG_CTL3, 8'hB0);
      chk_val(cfg, 7'b1100101);
      start;
      byte_out(8'h70, ack);
      stop;
      chk_val(ack, 1'b0);
      rd_ck(REG_CTL3, 8'hB0);
      reg_wr(REG_CTL2, 8'h30);
      hpd = 1'b1;
      tick(8);
      chk_val(monitor_sense_output, 1'b1);
      hpd = 1'b0;
      tick(8);
      chk_val(monitor_sense_output, 1'b0);
      reg_wr(REG_CTL2, 8'h20);
      chk_val(monitor_sense_output, 1'b1);
      rd_ck(REG_CTL2, 8'h25);
      reg_wr(REG_CTL2, 8'h10);
      chk_val(monitor_sense_output, 1'b1);
      reg_wr(REG_CTL2, 8'h11);
      chk_val(monitor_sense_output, 1'b0);
      reg_wr(REG_CTL2, 8'h18);
      reg_wr(REG_CTL2, 8'h19);
      hpd = 1'b1;
      tick(8);
      chk_val(monitor_sense_output, 1'b0);
      receiver_sense = 1'b0;
      tick(8);
      chk_val(monitor_sense_output, 1'b1);
      repeat (20) begin
         @(posedge pclk);
         #1;
         chk_val({opix, ode, ohs, ovs}, {pix, pde, phs, pvs});
      end
      reg_wr(REG_HOFF, 8'h04);
      reg_wr(REG_VOFF, 8'h02);
      reg_wr(REG_HLEN_LO, 8'h05);
      reg_wr(REG_VLEN_LO, 8'h03);
      reg_wr(REG_GCTL, 8'h70);
      repeat (300) @(posedge pclk);
      n = 0;
      repeat (128) begin
         @(posedge pclk);
         #1;
         n += int'(ode);
      end
      chk_val(24'(n), 24'd15);
      chk_val({ptot, ltot}, {11'd16, 11'd8});
      sel = 1'b0;
      tick(8);
      sel = 1'b1;
      tick(8);
      chk_val(cfg, {4'b1111, DESKEW_DEFAULT});
      rd_ck(REG_CTL3, 8'h00);
      conclude;
   end
   initial begin
      #2000000;
      miscompares++;
      conclude;
   end
endmodule // tb
